// [inc/nvr_defs.vh]
// shared constants for the non-volatile register read and busy poll block
`ifndef NVR_DEFS_VH
`define NVR_DEFS_VH

// ----------------------------------------------------------------
// command and address
// ----------------------------------------------------------------
`define NVR_OP_READ        8'h65
`define NVR_OP_WRITE       8'h00
`define NVR_ALEN_CODE      2'b10
`define NVR_STAT_ADDR      24'h000000
`define NVR_BUSY_BIT       0
`define NVR_BUSY_LOC       3'b000
`define NVR_WLAT_BIT       1

// ----------------------------------------------------------------
// protocol modes on proto_mode
// ----------------------------------------------------------------
`define NVR_MODE_1S        2'b00
`define NVR_MODE_8S        2'b01
`define NVR_MODE_8D        2'b10

// ----------------------------------------------------------------
// phase lengths, in link edges or link cycles
// ----------------------------------------------------------------
`define NVR_CMD_1S         6'h08
`define NVR_CMD_8S         6'h01
`define NVR_CMD_8D         6'h02
`define NVR_ADDR_1S        6'h18
`define NVR_ADDR_8X        6'h03
`define NVR_DUMMY_1S       6'h08
`define NVR_DUMMY_8X       6'h14
`define NVR_DCODE_1S       4'h8
`define NVR_DCODE_8X       4'hE
`define NVR_DBYTE_CODE     2'b10

// ----------------------------------------------------------------
// reported parameter words
// ----------------------------------------------------------------
`define NVR_PARAM_MAP4     32'hABFFFB88
`define NVR_PARAM_MAP5     32'h90006500

// ----------------------------------------------------------------
// pin positions and synchroniser width
// ----------------------------------------------------------------
`define NVR_SI_LANE        0
`define NVR_SO_LANE        1
`define NVR_SYNC_W         10

`endif

// [core/nvr_sync.v]
// three-stage synchroniser for link pins sampled by ref_clk
`timescale 1ns/10ps
`default_nettype none

module nvr_sync #(
  parameter W = 1                  // number of bits carried
) (
  input  wire         ref_clk,
  input  wire         rstn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync2,
  output wire [W-1:0] sync3
);

  // ----------------------------------------------------------------
  // per-bit flip-flop chains
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;                    // metastable stage, read by s2 only
      reg s2_q;                    // second stage
      reg s3_q;                    // third stage
      // reset value is a constant; pins are idle high only by caller
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign sync2[g] = s2_q;
      assign sync3[g] = s3_q;
    end
  endgenerate

endmodule

`default_nettype wire

// [core/nvr_cmd.v]
// link-side interpreter for the addressable non-volatile register read
//
// Operation
// RQ1 - opcode 65h selects non-volatile register read
// RQ2 - address length code reported as 10b
// RQ3 - code 10b means three address bytes
// RQ4 - octal SDR waits 20 dummy cycles, code 1110b
// RQ5 - octal DDR waits 20 dummy cycles, code 1110b
// RQ6 - single-lane SDR waits eight dummy cycles
// RQ7 - single-lane dummy byte count reported 10b
// RQ8 - read only; write opcode reported 00h
// RQ9 - busy flag lives at register 00h
// RQ10 - busy flag is bit 0, code 000b
// RQ11 - busy high while program/erase/write runs
// RQ12 - busy flag reachable by addressed reads
// RQ13 - host polls busy low before next write
`timescale 1ns/10ps
`default_nettype none
`include "nvr_defs.vh"

module nvr_cmd (
  input  wire        ref_clk,      // 25 MHz block clock
  input  wire        rstn,         // async reset, active low
  input  wire        sclk,         // link clock from host
  input  wire        cs_n,         // chip select, active low
  input  wire [7:0]  dq_in,        // link data lanes in
  output reg  [7:0]  dq_out,       // link data lanes out
  output reg  [7:0]  dq_oe_n,      // lane enables, low drives
  input  wire [1:0]  proto_mode,   // 1S, 8S or 8D, static
  input  wire        op_start,     // program/erase/write begins
  input  wire        op_done,      // that operation finished
  input  wire        write_latch_flag, // write enable latch state
  output reg         busy_flag,    // operation in progress
  output reg  [23:0] nvr_addr,     // register address to fetch
  output reg         nvr_rd,       // one-cycle fetch strobe
  input  wire [7:0]  nvr_data,     // fetched register value
  output reg  [31:0] param_map4,   // reported read parameters
  output reg  [31:0] param_map5    // reported busy parameters
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b000;
  localparam [2:0] ST_CMD   = 3'b001;
  localparam [2:0] ST_ADDR  = 3'b010;
  localparam [2:0] ST_DUMMY = 3'b011;
  localparam [2:0] ST_DATA  = 3'b100;
  localparam [2:0] ST_SKIP  = 3'b101;

  // ----------------------------------------------------------------
  // phase length decode, shared by the command, address and dummy phases
  // ----------------------------------------------------------------
  // sel: 0 command, 1 address, 2 dummy
  function [5:0] phase_len;
    input [1:0] mode;
    input [1:0] sel;
    begin
      phase_len = `NVR_DUMMY_8X;                       // RQ4 RQ5
      case (sel)
        2'd0: begin
          if (mode == `NVR_MODE_1S)
            phase_len = `NVR_CMD_1S;
          else if (mode == `NVR_MODE_8D)
            phase_len = `NVR_CMD_8D;
          else
            phase_len = `NVR_CMD_8S;
        end
        2'd1: begin
          // three address bytes in every mode
          if (mode == `NVR_MODE_1S)
            phase_len = `NVR_ADDR_1S;                  // RQ3
          else
            phase_len = `NVR_ADDR_8X;                  // RQ3
        end
        default: begin
          if (mode == `NVR_MODE_1S)
            phase_len = `NVR_DUMMY_1S;                 // RQ6 RQ7
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: sclk, cs_n and lanes share one depth so a
  // lane value is seen in the same cycle as the edge that owns it;
  // select enters inverted so the cleared chain reads deselected and
  // no false frame starts straight after reset
  // ----------------------------------------------------------------
  wire [`NVR_SYNC_W-1:0] pin_s2;   // second stage
  wire [`NVR_SYNC_W-1:0] pin_s3;   // third stage

  nvr_sync #(
    .W        (`NVR_SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({~cs_n, sclk, dq_in}),
    .sync2    (pin_s2),
    .sync3    (pin_s3)
  );

  wire [7:0] dq_s   = pin_s3[7:0];  // settled lane data
  wire       agree_c = (pin_s2[8] == pin_s3[8]);
  wire       agree_s = (pin_s2[9] == pin_s3[9]);

  reg        clk_lvl_q;            // accepted link clock level
  reg        cs_lvl_q;             // accepted chip select level

  // a change counts only once stages two and three agree
  wire rise_e = agree_c &  pin_s3[8] & ~clk_lvl_q;
  wire fall_e = agree_c & ~pin_s3[8] &  clk_lvl_q;
  wire cs_on  = agree_s &  pin_s3[9];

  wire single = (proto_mode == `NVR_MODE_1S);
  wire ddr    = (proto_mode == `NVR_MODE_8D);
  // capture edge in command/address phases; drive edge in data
  wire take_e = ddr ? (rise_e | fall_e) : rise_e;
  wire drv_e  = ddr ? (rise_e | fall_e) : fall_e;

  // ----------------------------------------------------------------
  // link decode state
  // ----------------------------------------------------------------
  reg [2:0]  st_q;                 // sequencer state
  reg [5:0]  cnt_q;                // units taken in this phase
  reg [31:0] sh_q;                 // incoming shift register
  reg [7:0]  out_q;                // outgoing byte

  // next shift value: one bit per edge on a single lane, else a byte
  wire [31:0] sh_in = single ? {sh_q[30:0], dq_s[`NVR_SI_LANE]}
                             : {sh_q[23:0], dq_s};
  wire [5:0]  last  = phase_len(proto_mode, {1'b0, st_q == ST_ADDR})
                      - 6'h01;
  wire [5:0]  dlast = phase_len(proto_mode, 2'd2) - 6'h01;
  // opcode sits in the first byte; the 8D extension byte is ignored
  wire [7:0]  opc   = ddr ? sh_in[15:8] : sh_in[7:0];
  // status byte holding the busy and write latch flags
  wire [7:0]  stat_byte = ({7'h00, busy_flag} << `NVR_BUSY_BIT)  // RQ10
                        | ({7'h00, write_latch_flag} << `NVR_WLAT_BIT);

  // ----------------------------------------------------------------
  // sequencer: cs high always returns to idle and frees the lanes
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_lvl_q <= 1'b0;
      cs_lvl_q  <= 1'b1;
      st_q      <= ST_IDLE;
      cnt_q     <= 6'h00;
      sh_q      <= 32'h00000000;
      out_q     <= 8'h00;
      nvr_addr  <= 24'h000000;
      nvr_rd    <= 1'b0;
      dq_out    <= 8'h00;
      dq_oe_n   <= 8'hFF;
    end else begin
      nvr_rd <= 1'b0;
      if (agree_c) begin
        clk_lvl_q <= pin_s3[8];
      end
      if (agree_s) begin
        cs_lvl_q <= ~pin_s3[9];
      end
      if (!cs_on) begin
        // deselected: idle and release every lane
        st_q    <= ST_IDLE;
        dq_oe_n <= 8'hFF;
      end else begin
        case (st_q)
          ST_IDLE: begin
            // new frame; only a fresh select starts decoding
            if (cs_lvl_q) begin
              st_q  <= ST_CMD;
              cnt_q <= 6'h00;
            end
          end
          ST_CMD: begin
            if (take_e) begin
              sh_q  <= sh_in;
              cnt_q <= cnt_q + 6'h01;
              if (cnt_q == last) begin
                cnt_q <= 6'h00;
                // only the read opcode is served; no write path exists
                if (opc == `NVR_OP_READ)             // RQ1 RQ8
                  st_q <= ST_ADDR;
                else
                  st_q <= ST_SKIP;
              end
            end
          end
          ST_ADDR: begin
            if (take_e) begin
              sh_q  <= sh_in;
              cnt_q <= cnt_q + 6'h01;
              if (cnt_q == last) begin
                cnt_q    <= 6'h00;
                nvr_addr <= sh_in[23:0];             // RQ2 RQ3
                nvr_rd   <= 1'b1;
                st_q     <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            // dummy cycles are counted on rising link edges
            if (rise_e) begin
              cnt_q <= cnt_q + 6'h01;
              if (cnt_q == dlast) begin              // RQ4 RQ5 RQ6
                cnt_q <= 6'h00;
                st_q  <= ST_DATA;
                // address 00h answers with the live status byte
                if (nvr_addr == `NVR_STAT_ADDR)      // RQ9 RQ12
                  out_q <= stat_byte;
                else
                  out_q <= nvr_data;
              end
            end
          end
          ST_DATA: begin
            // the byte repeats until the host ends the frame
            if (drv_e) begin
              if (single) begin
                dq_out[`NVR_SO_LANE]  <= out_q[7];
                dq_oe_n[`NVR_SO_LANE] <= 1'b0;
                out_q <= {out_q[6:0], out_q[7]};
              end else begin
                dq_out  <= out_q;
                dq_oe_n <= 8'h00;
              end
            end
          end
          ST_SKIP: begin
            // unsupported opcode: stay silent until deselect
            st_q <= ST_SKIP;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // busy flag: start wins over a done in the same cycle so an
  // operation that is restarted never shows a false idle
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_flag <= 1'b0;
    end else if (op_start) begin
      busy_flag <= 1'b1;                             // RQ11
    end else if (op_done) begin
      busy_flag <= 1'b0;                             // RQ11
    end
  end

  // ----------------------------------------------------------------
  // reported parameter words, fixed after reset
  // ----------------------------------------------------------------
  // word 4: dummy codes, dummy bytes, address length, support bits
  // word 5: busy location, polarity, write and read opcodes
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      param_map4 <= 32'h00000000;
      param_map5 <= 32'h00000000;
    end else begin
      param_map4 <= `NVR_PARAM_MAP4;                 // RQ2 RQ4 RQ5 RQ6 RQ7
      param_map5 <= `NVR_PARAM_MAP5;                 // RQ8 RQ9 RQ10 RQ12
    end
  end

endmodule

`default_nettype wire

// [test/nvr_cmd_asserts.sv]
// concurrent checks on the register read and busy poll block ports
`timescale 1ns/10ps
`default_nettype none

module nvr_cmd_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic [7:0]  dq_oe_n,
  input wire logic        op_start,
  input wire logic        op_done,
  input wire logic        busy_flag,
  input wire logic        nvr_rd,
  input wire logic [31:0] param_map4,
  input wire logic [31:0] param_map5
);
  // ----------
  // clocking and helpers
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic up_q;  // parameter words are valid from the first edge on
  // set one edge after release, so the reset values are not judged
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) up_q <= 1'b0;
    else up_q <= 1'b1;
  // chip select seen high long enough to pass the synchroniser
  sequence s_sel_idle;
    cs_n [*6];
  endsequence
  // ----------
  // properties
  // ----------
  property p_rd_op; up_q |-> param_map5[15:0] == 16'h6500; endproperty
  a_rd_op: assert property (p_rd_op) else $error("opcode map");
  property p_alen; up_q |-> param_map4[29:26] == 4'hA; endproperty
  a_alen: assert property (p_alen) else $error("length map");
  property p_dummy;
    up_q |-> {param_map4[13:6], param_map4[3:0]} == 12'hEE8;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy map");
  property p_busy_loc; up_q |-> param_map5[31:16] == 16'h9000; endproperty
  a_busy_loc: assert property (p_busy_loc) else $error("busy map");
  property p_busy_set; op_start |=> busy_flag; endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy set");
  property p_busy_clr; op_done && !op_start |=> !busy_flag; endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy clear");
  property p_busy_hold; !op_start && !op_done |=> $stable(busy_flag); endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy hold");
  property p_rd_pulse; nvr_rd |=> !nvr_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("fetch pulse");
  property p_oe_rel; s_sel_idle |-> dq_oe_n == 8'hFF; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("lanes held");
endmodule

bind nvr_cmd nvr_cmd_asserts i_chk (.*);
`default_nettype wire

// [test/nvr_host_model.sv]
// host model that runs register read frames over the link pins
`timescale 1ns/10ps
`default_nettype none
`include "nvr_defs.vh"

module nvr_host_model (
  output var logic       sclk,
  output var logic       cs_n,
  output var logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic [7:0] dq_oe_n
);
  // link idles with clock low and device deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_in = 8'h00;
  end
  // released lanes show the inverse of their last value, so a stale
  // byte from an earlier frame can never pass as an answer
  wire [7:0] bus_v;
  assign bus_v = dq_out ^ dq_oe_n;
  // one link edge; lanes move 80 ns ahead so they are settled at it
  task automatic tog(input logic [7:0] b);
    #80 dq_in = b;
    #80 sclk = ~sclk;
  endtask
  // whole frame; oe_at is the edge index where lanes were first driven
  task automatic frame(input logic [1:0] md, input logic [7:0] op,
      input logic [23:0] ad, output logic [7:0] rd, output int oe_at);
    logic [31:0] cw;
    logic [39:0] cx;
    int          nd;
    cw = {op, ad};
    cx = {op, ~op, ad};  // double rate carries a throwaway extension
    nd = (md == `NVR_MODE_1S) ? 8 : 20;
    rd = 8'h00;
    oe_at = -1;
    cs_n = 1'b0;
    case (md)
      `NVR_MODE_1S: for (int i = 63; i >= 0; i--) tog({7'h00, cw[i/2]});
      `NVR_MODE_8S: for (int i = 7; i >= 0; i--) tog(cw[(i/2)*8 +: 8]);
      default: for (int i = 4; i >= 0; i--) tog(cx[i*8 +: 8]);
    endcase
    // lanes let go: keep them moving so a stale value cannot pass
    for (int e = 0; e < 2 * nd + 16; e++) begin
      #80 dq_in = ~dq_in;
      if (oe_at < 0 && dq_oe_n !== 8'hFF) oe_at = e;
      if (sclk && e >= 2 * nd)
        rd = (md == `NVR_MODE_1S) ? {rd[6:0], bus_v[`NVR_SO_LANE]} : bus_v;
      #80 sclk = ~sclk;
    end
    // double rate ends high; one more half period brings it to idle
    if (sclk) #160 sclk = 1'b0;
    #160 cs_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// [test/nvr_cmd_tb.sv]
// self-checking bench for the register read and busy poll block
`timescale 1ns/10ps
`default_nettype none

module nvr_cmd_tb;
  logic        ref_clk, rstn, op_start, op_done, write_latch_flag;
  logic        sclk, cs_n, busy_flag, nvr_rd;
  logic [1:0]  proto_mode;
  logic [7:0]  nvr_data, dq_in, dq_out, dq_oe_n;
  logic [23:0] nvr_addr;
  logic [31:0] param_map4, param_map5;
  int          num_errors = 0;
  int          n_compared = 0;
  int          rd_cnt = 0;  // fetch strobes seen

  nvr_cmd i_dut (.*);
  nvr_host_model i_host (.*);

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (nvr_rd === 1'b1) rd_cnt++;

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // reported parameter words
  task automatic t_params;
    check("rd_op", param_map5[15:8], 8'h65);
    check("alen", param_map4[29:28], 2'b10);
    check("dum8s", param_map4[13:10], 4'hE);
    check("dum8d", param_map4[9:6], 4'hE);
    check("dum1s", param_map4[3:0], 4'h8);
    check("dbyte", param_map4[27:26], 2'b10);
    check("wr_op", param_map5[7:0], 8'h00);
    check("busy_reg", param_map5[23:16], 8'h00);
    check("busy_bit", param_map5[26:24], 3'b000);
    check("busy_acc", param_map5[28], 1'b1);
  endtask

  // one read in each mode; the drive edge index proves the dummy count
  task automatic t_read;
    logic [7:0] rd;
    int         oe_at, n0;
    for (int m = 0; m < 3; m++) begin
      @(negedge ref_clk);
      proto_mode = 2'(m);
      nvr_data = 8'hC1 + 8'(m);
      n0 = rd_cnt;
      i_host.frame(2'(m), 8'h65, 24'h5A3C81 + 24'(m), rd, oe_at);
      check("rd_data", rd, 8'hC1 + 8'(m));
      check("rd_addr", nvr_addr, 24'h5A3C81 + 24'(m));
      check("rd_strobe", rd_cnt - n0, 1);
      check("oe_edge", oe_at, m == 2 ? 42 : m == 1 ? 41 : 17);
    end
  endtask

  // a write opcode and a foreign opcode are both ignored
  task automatic t_refuse;
    logic [7:0] rd;
    int         oe_at, n0;
    n0 = rd_cnt;
    for (int k = 0; k < 2; k++) begin
      i_host.frame(proto_mode, k ? 8'h05 : 8'h00, 24'h0, rd, oe_at);
      check("wr_oe", oe_at, -1);
    end
    check("wr_strobe", rd_cnt - n0, 0);
  endtask

  // busy set, set winning over done, then polled until clear
  task automatic t_busy;
    logic [7:0] rd;
    int         oe_at, polls;
    @(negedge ref_clk) write_latch_flag = 1'b1;
    op_start = 1'b1;
    @(negedge ref_clk) op_start = 1'b0;
    check("busy_pin", busy_flag, 1'b1);
    i_host.frame(proto_mode, 8'h65, 24'h0, rd, oe_at);
    check("stat_busy", rd, 8'h03);
    @(negedge ref_clk) {op_start, op_done} = 2'b11;
    @(negedge ref_clk) {op_start, op_done} = 2'b01;
    check("busy_win", busy_flag, 1'b1);
    @(negedge ref_clk) op_done = 1'b0;
    check("busy_clr", busy_flag, 1'b0);
    polls = 0;
    // the host polls until the flag drops, three polls at most, before new work
    do begin
      i_host.frame(proto_mode, 8'h65, 24'h0, rd, oe_at);
      polls++;
    end while (rd[0] && polls < 3);
    check("stat_idle", rd, 8'h02);
    check("polls", polls, 1);
  endtask

  initial begin
    rstn = 1'b0;
    op_start = 1'b0;
    op_done = 1'b0;
    write_latch_flag = 1'b0;
    proto_mode = 2'b00;
    nvr_data = 8'h00;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    t_params;
    t_read;
    t_refuse;
    t_busy;
    summarize;
  end

  // watchdog well beyond the seven frames of the run
  initial begin
    #500000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
